// *** hdl/tsgc_clkdiv.sv ***
// reference clock predivider, produces a one-cycle tick per divided period
// assumes the high speed reference arrives as a synchronous enable
`timescale 1ns/100ps
module tsgc_clkdiv
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       ref_tick,
    input  wire logic [1:0] ref_clock_predivider,
    output logic            div_tick
);
    logic [1:0] cnt;
    logic [1:0] limit;
    always_comb
    begin
        case (ref_clock_predivider)
            2'h1:    limit = 2'h1;
            2'h2:    limit = 2'h3;
            default: limit = 2'h0;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt <= 2'h0;
        else if (ref_tick)
            cnt <= (cnt >= limit) ? 2'h0 : cnt + 2'h1;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_tick <= 1'b0;
        else
            div_tick <= ref_tick && (cnt >= limit);
    end
endmodule // tsgc_clkdiv

// *** hdl/tsgc_pkg.sv ***
// package for the tdc status and general configuration block
// assumes a 125 MHz core clock and an avalon-mm register master
package tsgc_pkg;
    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [3:0] TSGC_OFF_CFG    = 4'h0;
    localparam logic [3:0] TSGC_OFF_STATUS = 4'h4;
    localparam logic [3:0] TSGC_OFF_CMD    = 4'h8;
    localparam logic [3:0] TSGC_OFF_ID     = 4'hc;
    // ---------------------------------------------------------------
    // config field positions
    // ---------------------------------------------------------------
    localparam int TSGC_CFG_DIV_LSB    = 0;   // 2 bits
    localparam int TSGC_CFG_START_LSB  = 2;   // 3 bits
    localparam int TSGC_CFG_LOWCUR     = 5;
    localparam int TSGC_CFG_SNOISE     = 6;
    localparam int TSGC_CFG_PNDIS      = 7;
    localparam int TSGC_CFG_AUTOINIT   = 8;
    localparam int TSGC_CFG_ERRVAL     = 9;
    localparam int TSGC_CFG_QUAD       = 10;
    localparam int TSGC_CFG_DOUBLE     = 11;
    localparam int TSGC_CFG_MODE2      = 12;
    localparam logic [12:0] TSGC_CFG_RESET = 13'h0020;
    // ---------------------------------------------------------------
    // status bit positions
    // ---------------------------------------------------------------
    localparam int TSGC_ST_EQ      = 0;
    localparam int TSGC_ST_DED     = 1;
    localparam int TSGC_ST_SEC     = 2;
    localparam int TSGC_ST_SHORT   = 3;
    localparam int TSGC_ST_OPEN    = 4;
    localparam int TSGC_ST_PRECNT  = 5;
    localparam int TSGC_ST_TDC     = 6;
    localparam int TSGC_ST_SETTLED = 7;
    // ---------------------------------------------------------------
    // command opcodes and oscillator start codes
    // ---------------------------------------------------------------
    localparam logic [7:0] TSGC_OP_POR  = 8'h50;
    localparam logic [7:0] TSGC_OP_INIT = 8'h70;
    localparam logic [2:0] TSGC_OSC_OFF = 3'h0;
    localparam logic [2:0] TSGC_OSC_ON  = 3'h1;
    localparam logic [2:0] TSGC_OSC_480 = 3'h2;
    localparam logic [2:0] TSGC_OSC_1460 = 3'h3;
    localparam logic [2:0] TSGC_OSC_2440 = 3'h4;
    localparam logic [2:0] TSGC_OSC_5140 = 3'h5;
    localparam logic [31:0] TSGC_ERR_VALUE = 32'hffffffff;
    localparam int TSGC_PRECNT_W = 14;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int TSGC_CLK_MHZ   = 125;
    localparam int TSGC_T480_US   = 480;
    localparam int TSGC_T1460_US  = 1460;
    localparam int TSGC_T2440_US  = 2440;
    localparam int TSGC_T5140_US  = 5140;
    localparam int TSGC_C480   = TSGC_T480_US * TSGC_CLK_MHZ;
    localparam int TSGC_C1460  = TSGC_T1460_US * TSGC_CLK_MHZ;
    localparam int TSGC_C2440  = TSGC_T2440_US * TSGC_CLK_MHZ;
    localparam int TSGC_C5140  = TSGC_T5140_US * TSGC_CLK_MHZ;
    localparam logic [31:0] TSGC_ID_VALUE = 32'h5a5a0001; // arbitrary value
    typedef enum logic [1:0] {
        TSGC_OSC_IDLE  = 2'b00,
        TSGC_OSC_WAIT  = 2'b01,
        TSGC_OSC_READY = 2'b10
    } tsgc_osc_t;
endpackage

// *** hdl/tsgc_top.sv ***
// status flags and general configuration of the time-to-digital converter
// assumes avalon-mm master, event inputs synchronous to core_clk
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module tsgc_top
#(
    parameter int C480  = tsgc_pkg::TSGC_C480,
    parameter int C1460 = tsgc_pkg::TSGC_C1460,
    parameter int C2440 = tsgc_pkg::TSGC_C2440,
    parameter int C5140 = tsgc_pkg::TSGC_C5140
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        high_speed_ref_clock,
    input  wire logic [31:0] nvm_image,
    input  wire logic        nvm_read_done,
    input  wire logic        nvm_corrected,
    input  wire logic        nvm_uncorrectable_error,
    input  wire logic        temp_short,
    input  wire logic        temp_open,
    input  wire logic        meas_request,
    input  wire logic        precount_tick,
    input  wire logic        tdc_overflow,
    input  wire logic        meas_irq,
    input  wire logic        alu_result_valid,
    input  wire logic [31:0] alu_result_in,
    output logic [31:0]      result_word,
    output logic             osc_enable,
    output logic             osc_ready,
    output logic             ref_div_tick,
    output logic             osc32_low_current,
    output logic             start_noise_enable,
    output logic             phase_noise_disable,
    output logic             fourfold_resolution,
    output logic             twofold_resolution,
    output logic             init_pulse
);
    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic [12:0] cfg;
    logic [7:0]  status;
    logic        ack;
    logic        soft_por;
    logic        next_init;
    logic        fast_init_req;
    logic        access;
    assign access   = (avs_read || avs_write) && !ack;
    // one wait state per access: waitrequest low in the second cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ack <= 1'b0;
        else
            ack <= access;
    end
    // registered complement of ack, so the bus sees no combinational path
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !access;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= 32'h0;
        else if (access && avs_read)
        begin
            case (avs_address)
                tsgc_pkg::TSGC_OFF_CFG:    avs_readdata <= {19'h0, cfg};
                tsgc_pkg::TSGC_OFF_STATUS: avs_readdata <= {24'h0, status};
                tsgc_pkg::TSGC_OFF_ID:     avs_readdata <= tsgc_pkg::TSGC_ID_VALUE;
                default:                   avs_readdata <= 32'h0;
            endcase
        end
    end
    logic wr_cmd;
    assign wr_cmd = ack && avs_write && (avs_address == tsgc_pkg::TSGC_OFF_CMD);
    // ---------------------------------------------------------------
    // commands
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            soft_por <= 1'b0;
        else
            soft_por <= wr_cmd && (avs_writedata[7:0] == tsgc_pkg::TSGC_OP_POR);
    end
    assign fast_init_req = meas_irq && cfg[tsgc_pkg::TSGC_CFG_AUTOINIT];
    assign next_init = (wr_cmd && (avs_writedata[7:0] == tsgc_pkg::TSGC_OP_INIT))
                     || fast_init_req;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            init_pulse <= 1'b0;
        else
            init_pulse <= next_init && !soft_por;
    end
    // ---------------------------------------------------------------
    // configuration
    // ---------------------------------------------------------------
    logic [12:0] next_cfg;
    always_comb
    begin
        next_cfg = avs_writedata[12:0];
        if (!next_cfg[tsgc_pkg::TSGC_CFG_MODE2])
            next_cfg[tsgc_pkg::TSGC_CFG_QUAD] = 1'b0;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cfg <= tsgc_pkg::TSGC_CFG_RESET;
        else if (soft_por)
            cfg <= tsgc_pkg::TSGC_CFG_RESET;
        else if (ack && avs_write && avs_address == tsgc_pkg::TSGC_OFF_CFG)
            cfg <= next_cfg;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osc32_low_current   <= 1'b1;
            start_noise_enable  <= 1'b0;
            phase_noise_disable <= 1'b0;
            fourfold_resolution <= 1'b0;
            twofold_resolution  <= 1'b0;
        end
        else
        begin
            osc32_low_current   <= cfg[tsgc_pkg::TSGC_CFG_LOWCUR];
            start_noise_enable  <= cfg[tsgc_pkg::TSGC_CFG_SNOISE];
            phase_noise_disable <= cfg[tsgc_pkg::TSGC_CFG_PNDIS];
            fourfold_resolution <= cfg[tsgc_pkg::TSGC_CFG_QUAD]
                                && cfg[tsgc_pkg::TSGC_CFG_MODE2];
            twofold_resolution  <= cfg[tsgc_pkg::TSGC_CFG_DOUBLE];
        end
    end
    // ---------------------------------------------------------------
    // predivider
    // ---------------------------------------------------------------
    tsgc_clkdiv u_div
    (
        .core_clk             (core_clk),
        .rst_b                (rst_b),
        .ref_tick             (high_speed_ref_clock),
        .ref_clock_predivider (cfg[1:0]),
        .div_tick             (ref_div_tick)
    );
    // ---------------------------------------------------------------
    // oscillator start and settling
    // ---------------------------------------------------------------
    tsgc_pkg::tsgc_osc_t osc_st;
    logic [31:0] settle_cnt;
    logic [31:0] settle_lim;
    logic [2:0]  osc_mode;
    assign osc_mode = cfg[4:2];
    always_comb
    begin
        case (osc_mode)
            tsgc_pkg::TSGC_OSC_480:  settle_lim = 32'(C480);
            tsgc_pkg::TSGC_OSC_1460: settle_lim = 32'(C1460);
            tsgc_pkg::TSGC_OSC_2440: settle_lim = 32'(C2440);
            tsgc_pkg::TSGC_OSC_5140: settle_lim = 32'(C5140);
            default:                 settle_lim = 32'h1;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            osc_st <= tsgc_pkg::TSGC_OSC_IDLE;
        else if (soft_por)
            osc_st <= tsgc_pkg::TSGC_OSC_IDLE;
        else
        begin
            case (osc_st)
                tsgc_pkg::TSGC_OSC_IDLE:
                    if (osc_mode == tsgc_pkg::TSGC_OSC_ON)
                        osc_st <= tsgc_pkg::TSGC_OSC_READY;
                    else if (meas_request && osc_mode != tsgc_pkg::TSGC_OSC_OFF)
                        osc_st <= tsgc_pkg::TSGC_OSC_WAIT;
                tsgc_pkg::TSGC_OSC_WAIT:
                    if (osc_mode == tsgc_pkg::TSGC_OSC_OFF)
                        osc_st <= tsgc_pkg::TSGC_OSC_IDLE;
                    else if (settle_cnt + 32'h1 >= settle_lim)
                        osc_st <= tsgc_pkg::TSGC_OSC_READY;
                tsgc_pkg::TSGC_OSC_READY:
                    if (osc_mode == tsgc_pkg::TSGC_OSC_OFF)
                        osc_st <= tsgc_pkg::TSGC_OSC_IDLE;
                    else if (osc_mode != tsgc_pkg::TSGC_OSC_ON && meas_irq)
                        osc_st <= tsgc_pkg::TSGC_OSC_IDLE;
                default:
                    osc_st <= tsgc_pkg::TSGC_OSC_IDLE;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            settle_cnt <= 32'h0;
        else if (osc_st == tsgc_pkg::TSGC_OSC_WAIT)
            settle_cnt <= settle_cnt + 32'h1;
        else
            settle_cnt <= 32'h0;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            osc_enable <= 1'b0;
            osc_ready  <= 1'b0;
        end
        else
        begin
            osc_enable <= (osc_st != tsgc_pkg::TSGC_OSC_IDLE);
            osc_ready  <= (osc_st == tsgc_pkg::TSGC_OSC_READY);
        end
    end
    // ---------------------------------------------------------------
    // status flags; set wins over init clear
    // ---------------------------------------------------------------
    logic [13:0] precnt;
    logic        precnt_ovf;
    logic        mode2;
    assign mode2      = cfg[tsgc_pkg::TSGC_CFG_MODE2];
    assign precnt_ovf = mode2 && precount_tick && (&precnt);
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            precnt <= 14'h0;
        else if (soft_por || next_init)
            precnt <= 14'h0;
        else if (mode2 && precount_tick)
            precnt <= precnt + 14'h1;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            status[6:0] <= 7'h0;
        else if (soft_por)
            status[6:0] <= 7'h0;
        else
        begin
            if (nvm_read_done)
                status[tsgc_pkg::TSGC_ST_EQ] <= (nvm_image[12:0] == cfg);
            if (nvm_uncorrectable_error)
                status[tsgc_pkg::TSGC_ST_DED] <= 1'b1;
            if (nvm_corrected)
                status[tsgc_pkg::TSGC_ST_SEC] <= 1'b1;
            if (temp_short)
                status[tsgc_pkg::TSGC_ST_SHORT] <= 1'b1;
            if (temp_open)
                status[tsgc_pkg::TSGC_ST_OPEN] <= 1'b1;
            if (precnt_ovf)
                status[tsgc_pkg::TSGC_ST_PRECNT] <= 1'b1;
            else if (next_init)
                status[tsgc_pkg::TSGC_ST_PRECNT] <= 1'b0;
            if (tdc_overflow)
                status[tsgc_pkg::TSGC_ST_TDC] <= 1'b1;
            else if (next_init)
                status[tsgc_pkg::TSGC_ST_TDC] <= 1'b0;
        end
    end
    assign status[tsgc_pkg::TSGC_ST_SETTLED] = osc_ready;
    // ---------------------------------------------------------------
    // result word
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            result_word <= 32'h0;
        else if (alu_result_valid)
        begin
            if (cfg[tsgc_pkg::TSGC_CFG_ERRVAL] && (status[5] || status[6]))
                result_word <= tsgc_pkg::TSGC_ERR_VALUE;
            else
                result_word <= alu_result_in;
        end
    end
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_tdc_flag_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        tdc_overflow && !soft_por |=> status[tsgc_pkg::TSGC_ST_TDC])
        else $error("tdc timeout flag not set");
    a_init_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
        next_init && !tdc_overflow && !soft_por |=> !status[tsgc_pkg::TSGC_ST_TDC])
        else $error("init did not clear tdc flag");
    a_fast_init: assert property (@(posedge core_clk) disable iff (!rst_b)
        meas_irq && cfg[tsgc_pkg::TSGC_CFG_AUTOINIT] && !soft_por |=> init_pulse)
        else $error("fast init missing");
    a_por_cfg: assert property (@(posedge core_clk) disable iff (!rst_b)
        soft_por |=> cfg == tsgc_pkg::TSGC_CFG_RESET)
        else $error("por did not reset config");
    a_quad_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        fourfold_resolution |-> $past(cfg[tsgc_pkg::TSGC_CFG_MODE2]))
        else $error("quad outside mode two");
    a_err_value: assert property (@(posedge core_clk) disable iff (!rst_b)
        alu_result_valid && cfg[tsgc_pkg::TSGC_CFG_ERRVAL] && status[6]
        |=> result_word == tsgc_pkg::TSGC_ERR_VALUE)
        else $error("error value not written");
    a_short_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        temp_short && !soft_por |=> status[tsgc_pkg::TSGC_ST_SHORT])
        else $error("short flag not set");
    a_osc_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        osc_mode == tsgc_pkg::TSGC_OSC_OFF [*3] |-> !osc_ready)
        else $error("oscillator ready while off");
    a_precnt_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        precnt_ovf && !soft_por |=> status[tsgc_pkg::TSGC_ST_PRECNT])
        else $error("precounter timeout flag not set");
    a_por_status: assert property (@(posedge core_clk) disable iff (!rst_b)
        soft_por |=> status[6:0] == 7'h0)
        else $error("por did not clear status flags");
endmodule // tsgc_top

// *** testbench/tb.sv ***
// self-checking bench for the status and general configuration block
// assumes settle counts shortened to 20/40/60/80 cycles
`timescale 1ns/100ps
module tb;
    localparam int C[4] = '{20, 40, 60, 80};
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        hs       = 1'b0;
    logic [9:0]  ev       = 10'h0;
    logic [31:0] nvm      = 32'h0;
    logic [31:0] alu      = 32'h0;
    logic [31:0] q;
    logic [31:0] res;
    logic [3:0]  adr;
    logic        rd;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] rdata;
    logic        wait_n;
    logic        oen;
    logic        ordy;
    logic        dtk;
    logic        lowc;
    logic        sn;
    logic        pnd;
    logic        ff;
    logic        tf;
    logic        ip;
    int          num_errors = 0;
    int          checks     = 0;
    int          n_init     = 0;
    int          n_div      = 0;
    int          ecfg;
    int          est;
    int          n;

    always #4 core_clk = !core_clk;

    always @(posedge core_clk)
    begin
        if (ip === 1'b1)
            n_init++;
        if (dtk === 1'b1)
            n_div++;
    end

    tsgc_host i_host (.core_clk(core_clk), .avs_waitrequest(wait_n), .avs_readdata(rdata),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd));

    tsgc_top #(.C480(20), .C1460(40), .C2440(60), .C5140(80)) i_tsgc_top (
        .core_clk(core_clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wait_n), .high_speed_ref_clock(hs), .nvm_image(nvm),
        .nvm_read_done(ev[0]), .nvm_corrected(ev[1]), .nvm_uncorrectable_error(ev[2]),
        .temp_short(ev[3]), .temp_open(ev[4]), .meas_request(ev[5]),
        .precount_tick(ev[6]), .tdc_overflow(ev[7]), .meas_irq(ev[8]),
        .alu_result_valid(ev[9]), .alu_result_in(alu), .result_word(res),
        .osc_enable(oen), .osc_ready(ordy), .ref_div_tick(dtk),
        .osc32_low_current(lowc), .start_noise_enable(sn), .phase_noise_disable(pnd),
        .fourfold_resolution(ff), .twofold_resolution(tf), .init_pulse(ip));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrc(input logic [3:0] a, input int d);
        i_host.xfer(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] m, input int e);
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    task automatic pulse(input int b);
        @(posedge core_clk);
        ev[b] <= 1'b1;
        @(posedge core_clk);
        ev[b] <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // budget far above the ~20k cycles the sequence needs
    initial
    begin
        #(8 * 60000);
        num_errors++;
        test_done;
    end

    initial
    begin
        void'($urandom(32'hf96b));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rdc(tsgc_pkg::TSGC_OFF_CFG, 32'h1fff, 32'h20);
        chk(lowc, 1'b1);
        rdc(tsgc_pkg::TSGC_OFF_ID, 32'hffffffff, tsgc_pkg::TSGC_ID_VALUE);
        rdc(4'h1, 32'hffffffff, 0);
        i_host.cmd(tsgc_pkg::TSGC_OP_POR);
        for (int i = 0; i < 6; i++)
        begin
            est  = $urandom & 32'h1fe1;
            ecfg = est & ~((~est >> 2) & 32'h400); // quad kept only with mode two
            wrc(tsgc_pkg::TSGC_OFF_CFG, est);
            rdc(tsgc_pkg::TSGC_OFF_CFG, 32'h1fff, ecfg);
            chk({sn, pnd, tf, ff, lowc}, {ecfg[6], ecfg[7], ecfg[11], ecfg[10] & ecfg[12],
                ecfg[5]});
            nvm <= ecfg ^ (i[0] ? 32'h400 : 32'h0);
            pulse(0);
            rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h1, !i[0]);
        end
        i_host.cmd(tsgc_pkg::TSGC_OP_INIT);
        est = 0;
        for (int i = 0; i < 5; i++)
        begin
            n = (i < 4) ? i + 1 : 7;
            pulse(n);
            est |= 1 << ((i == 0) ? 2 : (i == 1) ? 1 : (i == 4) ? 6 : i + 1);
            rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h7e, est);
        end
        n = n_init;
        i_host.cmd(tsgc_pkg::TSGC_OP_INIT);
        est &= 32'h1e;
        repeat (2) @(negedge core_clk);
        chk(n_init, n + 1);
        rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h7e, est);
        rdc(tsgc_pkg::TSGC_OFF_CFG, 32'h1fff, ecfg);
        for (int f = 0; f < 2; f++)
        begin
            wrc(tsgc_pkg::TSGC_OFF_CFG, 32'h200 | (f << 8));
            pulse(7);
            @(posedge core_clk);
            alu <= $urandom;
            pulse(9);
            chk(res, 32'hffffffff);
            n = n_init;
            pulse(8);
            repeat (3) @(posedge core_clk);
            chk(n_init, n + f);
            rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h40, f ? 0 : 32'h40);
        end
        pulse(9);
        chk(res, alu);
        for (int d = 0; d < 3; d++)
        begin
            wrc(tsgc_pkg::TSGC_OFF_CFG, d | 32'h4);
            repeat (3) @(posedge core_clk);
            chk(oen, 1'b1);
            n_div = 0;
            hs <= 1'b1;
            repeat (64) @(posedge core_clk);
            hs <= 1'b0;
            @(negedge core_clk);
            chk(n_div + 1, 64 >> d);
        end
        for (int k = 0; k < 4; k++)
        begin
            wrc(tsgc_pkg::TSGC_OFF_CFG, (k + 2) << 2);
            pulse(8);
            pulse(5);
            n = 1;
            while (ordy !== 1'b1 && n < 300)
            begin
                @(negedge core_clk);
                n++;
            end
            chk(n, C[k] + 2);
            pulse(8);
        end
        wrc(tsgc_pkg::TSGC_OFF_CFG, 0);
        pulse(5);
        repeat (100) @(posedge core_clk);
        chk(oen, 1'b0);
        wrc(tsgc_pkg::TSGC_OFF_CFG, 32'h1000);
        ev[6] <= 1'b1;
        repeat (16383) @(posedge core_clk);
        ev[6] <= 1'b0;
        rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h20, 0);
        pulse(6);
        rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h20, 32'h20);
        i_host.cmd(tsgc_pkg::TSGC_OP_POR);
        rdc(tsgc_pkg::TSGC_OFF_CFG, 32'h1fff, 32'h20);
        rdc(tsgc_pkg::TSGC_OFF_STATUS, 32'h7e, 0);
        test_done;
    end
endmodule // tb

// *** testbench/tsgc_host.sv ***
// host model: avalon-mm register master issuing commands to the block
// assumes core_clk runs and the slave answers through waitrequest
`timescale 1ns/100ps
module tsgc_host
(
    input  wire logic        core_clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic [3:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata
);
    // ---------------------------------------------------------------
    // bus cycles
    // ---------------------------------------------------------------
    initial
    begin
        avs_address   = 4'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
    end

    // request held until the rising edge that samples waitrequest low
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
    endtask

    // opcode written to the command register
    task automatic cmd(input logic [7:0] op);
        logic [31:0] q;
        xfer(1'b1, tsgc_pkg::TSGC_OFF_CMD, {24'h0, op}, q);
    endtask
endmodule // tsgc_host
